// [dv/host_bus_model.sv]
// Host-side bus model that reads and writes the host register set
`timescale 1ns/10ps
module host_bus_model (
    input  wire logic           core_clk,
    input  wire rxq_pkg::byte_t hst_rdata,
    output      rxq_pkg::addr_t hst_addr,
    output      rxq_pkg::byte_t hst_wdata,
    output      logic           hst_wr,
    output      logic           hst_rd
);
    import rxq_pkg::*;

    // ----------------------------------------------------------------
    // Idle bus
    // ----------------------------------------------------------------
    initial begin
        hst_addr  = 3'h0;
        hst_wdata = 8'h00;
        hst_wr    = 1'b0;
        hst_rd    = 1'b0;
    end

    // ----------------------------------------------------------------
    // One-cycle write; released lines show the inverse value
    // ----------------------------------------------------------------
    task automatic host_write(input addr_t a, input byte_t d);
        @(posedge core_clk);
        hst_addr  <= a;
        hst_wdata <= d;
        hst_wr    <= 1'b1;
        @(posedge core_clk);
        hst_wr    <= 1'b0;
        hst_addr  <= ~a;
        hst_wdata <= ~d;
    endtask

    // ----------------------------------------------------------------
    // One-cycle read; data taken in the cycle after the strobe
    // ----------------------------------------------------------------
    task automatic host_read(input addr_t a, output byte_t d);
        @(posedge core_clk);
        hst_addr <= a;
        hst_rd   <= 1'b1;
        @(posedge core_clk);
        hst_rd   <= 1'b0;
        hst_addr <= ~a;
        #1;
        d = hst_rdata;
    endtask
endmodule

// [dv/testbench.sv]
// Self-checking bench of the host receive queue with error bits
`timescale 1ns/10ps
`define CHK(w, e, g) check_val(w, e, g)
module testbench;
    import rxq_pkg::*;

    localparam addr_t loc_data_a   = 3'h0;
    localparam addr_t loc_pend_a   = 3'h2;
    localparam addr_t loc_mask_a   = 3'h3;
    localparam addr_t loc_count_a  = 3'h4;
    localparam addr_t loc_shadow_a = 3'h5;
    localparam addr_t hst_data_a   = 3'h0;
    localparam addr_t hst_en_a     = 3'h1;
    localparam addr_t hst_qctl_a   = 3'h2;
    localparam addr_t hst_status_a = 3'h5;

    logic  core_clk;
    logic  rst_n;
    addr_t lcl_addr;
    byte_t lcl_wdata;
    logic  lcl_wr;
    logic  lcl_rd;
    byte_t lcl_rdata;
    addr_t hst_addr;
    byte_t hst_wdata;
    logic  hst_wr;
    logic  hst_rd;
    byte_t hst_rdata;
    logic  irq_host;
    logic  irq_lcl;
    int    mismatches;
    int    samples_checked;
    int    cycles;
    byte_t rd;
    byte_t trig_tab [4] = '{8'h01, 8'h04, 8'h08, 8'h0e};

    host_uart_rx_fifo_errbits dut_u (
        .core_clk (core_clk),  .rst_n     (rst_n),
        .lcl_addr (lcl_addr),  .lcl_wdata (lcl_wdata),
        .lcl_wr   (lcl_wr),    .lcl_rd    (lcl_rd),
        .lcl_rdata(lcl_rdata), .hst_addr  (hst_addr),
        .hst_wdata(hst_wdata), .hst_wr    (hst_wr),
        .hst_rd   (hst_rd),    .hst_rdata (hst_rdata),
        .irq_host (irq_host),  .irq_lcl   (irq_lcl)
    );

    host_bus_model host_u (
        .core_clk (core_clk),  .hst_rdata (hst_rdata),
        .hst_addr (hst_addr),  .hst_wdata (hst_wdata),
        .hst_wr   (hst_wr),    .hst_rd    (hst_rd)
    );

    // ----------------------------------------------------------------
    // Clock and hang guard
    // ----------------------------------------------------------------
    initial begin
        core_clk = 1'b0;
        forever #4 core_clk = ~core_clk;
    end

    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 4000) begin
            mismatches++;
            report_and_stop();
        end
    end

    // ----------------------------------------------------------------
    // Tasks
    // ----------------------------------------------------------------
    task automatic check_val(input string w, input byte_t e, input byte_t g);
        samples_checked++;
        if (g !== e) begin
            mismatches++;
            $display("[FAIL] %s expected %h seen %h", w, e, g);
        end
    endtask

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    task automatic lcl_write(input addr_t a, input byte_t d);
        @(posedge core_clk);
        lcl_addr  <= a;
        lcl_wdata <= d;
        lcl_wr    <= 1'b1;
        @(posedge core_clk);
        lcl_wr    <= 1'b0;
        lcl_addr  <= ~a;
        lcl_wdata <= ~d;
    endtask

    task automatic lcl_read(input addr_t a, output byte_t d);
        @(posedge core_clk);
        lcl_addr <= a;
        lcl_rd   <= 1'b1;
        @(posedge core_clk);
        lcl_rd   <= 1'b0;
        lcl_addr <= ~a;
        #1;
        d = lcl_rdata;
    endtask

    task automatic push(input byte_t err, input byte_t chr);
        lcl_write(loc_shadow_a, err);
        lcl_write(loc_data_a, chr);
    endtask

    task automatic pop_check(input byte_t e);
        byte_t d;
        host_u.host_read(hst_data_a, d);
        `CHK("host data", e, d);
    endtask

    task automatic status_check(input byte_t e);
        byte_t d;
        repeat (2) @(posedge core_clk);
        host_u.host_read(hst_status_a, d);
        `CHK("host status", e, d);
    endtask

    task automatic wait_cycles(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask

    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial begin
        rst_n = 1'b0;
        lcl_addr = 3'h0;
        lcl_wdata = 8'h00;
        lcl_wr = 1'b0;
        lcl_rd = 1'b0;
        mismatches = 0;
        samples_checked = 0;
        cycles = 0;
        repeat (6) @(posedge core_clk);
        rst_n <= 1'b1;
        wait_cycles(1);
        `CHK("irq host", 8'h00, {7'h00, irq_host});
        `CHK("irq local", 8'h00, {7'h00, irq_lcl});
        lcl_read(loc_count_a, rd);
        `CHK("count", 8'h00, rd);
        status_check(8'h00);
        // Error flags travel with their characters
        host_u.host_write(hst_qctl_a, 8'h01);
        host_u.host_write(hst_en_a, 8'h04);
        lcl_write(loc_mask_a, 8'h60);
        lcl_read(loc_mask_a, rd);
        `CHK("mask", 8'h60, rd);
        push(8'h04, 8'ha1);
        push(8'h10, 8'ha2);
        lcl_write(loc_data_a, 8'ha3);
        push(8'h08, 8'ha4);
        lcl_read(loc_count_a, rd);
        `CHK("count", 8'h04, rd);
        wait_cycles(2);
        `CHK("irq host", 8'h01, {7'h00, irq_host});
        status_check(8'h05);
        status_check(8'h01);
        wait_cycles(2);
        `CHK("irq host", 8'h00, {7'h00, irq_host});
        pop_check(8'ha1);
        pop_check(8'ha2);
        status_check(8'h11);
        status_check(8'h01);
        pop_check(8'ha3);
        status_check(8'h09);
        `CHK("irq local", 8'h00, {7'h00, irq_lcl});
        pop_check(8'ha4);
        wait_cycles(2);
        `CHK("irq local", 8'h01, {7'h00, irq_lcl});
        lcl_read(loc_pend_a, rd);
        `CHK("pending", 8'h20, rd);
        lcl_read(loc_pend_a, rd);
        `CHK("pending", 8'h00, rd);
        status_check(8'h00);
        // Every threshold code
        host_u.host_write(hst_en_a, 8'h01);
        host_u.host_read(hst_en_a, rd);
        `CHK("enable", 8'h01, rd);
        for (int t = 0; t < 4; t++) begin
            host_u.host_write(hst_qctl_a, {t[1:0], 6'h01});
            for (int i = 1; i < trig_tab[t]; i++) begin
                lcl_write(loc_data_a, byte_t'(i));
            end
            wait_cycles(2);
            `CHK("irq below", 8'h00, {7'h00, irq_host});
            lcl_write(loc_data_a, 8'hff);
            wait_cycles(2);
            `CHK("irq at trig", 8'h01, {7'h00, irq_host});
            for (int i = 0; i < trig_tab[t]; i++) begin
                host_u.host_read(hst_data_a, rd);
            end
        end
        // Fill past full, then drain past empty
        lcl_write(loc_pend_a, 8'h60);
        for (int i = 0; i < 17; i++) begin
            lcl_write(loc_data_a, byte_t'(8'h30 + i));
        end
        lcl_read(loc_count_a, rd);
        `CHK("count", 8'h10, rd);
        lcl_read(loc_pend_a, rd);
        `CHK("pending", 8'h40, rd);
        `CHK("irq drop", 8'h01, {7'h00, irq_lcl});
        for (int i = 0; i < 16; i++) begin
            pop_check(byte_t'(8'h30 + i));
        end
        host_u.host_read(hst_data_a, rd);
        `CHK("empty read", 8'h00, rd);
        lcl_read(loc_count_a, rd);
        `CHK("count", 8'h00, rd);
        // Queue mode off: threshold one, no empty pending bit
        lcl_write(loc_pend_a, 8'h60);
        host_u.host_write(hst_qctl_a, 8'hc0);
        lcl_write(loc_data_a, 8'h55);
        wait_cycles(2);
        `CHK("irq mode off", 8'h01, {7'h00, irq_host});
        pop_check(8'h55);
        lcl_read(loc_pend_a, rd);
        `CHK("pending", 8'h00, rd);
        report_and_stop();
    end
endmodule

// [logic/host_uart_rx_fifo_errbits.sv]
// Host receive queue with error bits, host and local register ports
`timescale 1ns/10ps
`include "rxq_params.svh"
module host_uart_rx_fifo_errbits (
    input  wire logic           core_clk,
    input  wire logic           rst_n,
    input  wire rxq_pkg::addr_t lcl_addr,
    input  wire rxq_pkg::byte_t lcl_wdata,
    input  wire logic           lcl_wr,
    input  wire logic           lcl_rd,
    output      rxq_pkg::byte_t lcl_rdata,
    input  wire rxq_pkg::addr_t hst_addr,
    input  wire rxq_pkg::byte_t hst_wdata,
    input  wire logic           hst_wr,
    input  wire logic           hst_rd,
    output      rxq_pkg::byte_t hst_rdata,
    output      logic           irq_host,
    output      logic           irq_lcl
);
    import rxq_pkg::*;

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        err3_t       shadow;
        err3_t       err;
        logic        arrive;
        logic        qc_en;
        logic [1:0]  trig;
        logic        ier_rda;
        logic        ier_rls;
        logic [1:0]  pend;
        logic [1:0]  mask;
        byte_t       lcl_rdata;
        byte_t       hst_rdata;
        logic        irq_host;
        logic        irq_lcl;
    } ctl_state_t;

    ctl_state_t cur_ff;
    ctl_state_t nxt_st;

    logic       push_req;
    logic       push_ok;
    logic       pop_req;
    logic       pop_ok;
    logic       lstat_rd;
    logic       pend_rd;
    logic       shadow_wr;
    logic       becomes_empty;
    qcnt_t      thr;

    rxq_if q_if ();

    queue_store u_store (
        .core_clk (core_clk),
        .rst_n    (rst_n),
        .q        (q_if.store)
    );

    // ------------------------------------------------------------
    // Access decode
    // ------------------------------------------------------------
    assign push_req  = lcl_wr && (lcl_addr == `LCL_RXDATA);
    assign push_ok   = push_req && !q_if.full;              // see RULE12
    assign pop_req   = hst_rd && (hst_addr == `HST_RXDATA);
    assign pop_ok    = pop_req && !q_if.empty;              // see RULE12
    assign lstat_rd  = hst_rd && (hst_addr == `HST_LSTAT);
    assign pend_rd   = lcl_rd && (lcl_addr == `LCL_IRQ_PEND);
    assign shadow_wr = lcl_wr && (lcl_addr == `LCL_SHADOW); // see RULE4

    assign becomes_empty = pop_ok && !push_ok
                           && (q_if.count == qcnt_t'(1));

    // ------------------------------------------------------------
    // Queue port
    // ------------------------------------------------------------
    assign q_if.push             = push_ok;
    assign q_if.push_entry.chr   = lcl_wdata;               // see RULE5
    assign q_if.push_entry.flags = cur_ff.shadow;           // see RULE2
    assign q_if.pop              = pop_ok;

    // ------------------------------------------------------------
    // Receive threshold
    // ------------------------------------------------------------
    always_comb begin
        thr = `TRIG_1;
        if (cur_ff.qc_en) begin
            unique case (cur_ff.trig)
                2'h0: thr = `TRIG_1;
                2'h1: thr = `TRIG_4;
                2'h2: thr = `TRIG_8;
                2'h3: thr = `TRIG_14;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        nxt_st           = cur_ff;
        nxt_st.lcl_rdata = '0;
        nxt_st.hst_rdata = '0;

        // Shadow error bits
        if (shadow_wr) begin
            nxt_st.shadow = lcl_wdata[`LST_ERR_HI:`LST_ERR_LO]; // see RULE2
        end else if (push_ok) begin
            nxt_st.shadow = '0;                                 // see RULE3
        end

        // A new entry reaches the head in the following cycle
        nxt_st.arrive = (push_ok && (q_if.empty
                         || (pop_ok && q_if.count == qcnt_t'(1))))
                        || (pop_ok && q_if.count > qcnt_t'(1));

        // Host error status: set wins over the read clear
        if (lstat_rd) begin
            nxt_st.err = '0;                                    // see RULE8
        end
        if (cur_ff.arrive && !q_if.empty) begin
            nxt_st.err = nxt_st.err | q_if.head.flags;  // see RULE6, RULE9
        end

        // Host register writes
        if (hst_wr) begin
            unique case (hst_addr)
                `HST_IER: begin
                    nxt_st.ier_rda = hst_wdata[`IER_RDA_BIT];
                    nxt_st.ier_rls = hst_wdata[`IER_RLS_BIT];
                end
                `HST_QCTRL: begin
                    nxt_st.qc_en = hst_wdata[`QC_EN_BIT];
                    nxt_st.trig  = hst_wdata[`QC_TRIG_HI:`QC_TRIG_LO];
                end
                default: begin
                end
            endcase
        end

        // Host register reads
        if (hst_rd) begin
            unique case (hst_addr)
                `HST_RXDATA: begin
                    if (pop_ok) begin
                        nxt_st.hst_rdata = q_if.head.chr;
                    end
                end
                `HST_IER: begin
                    nxt_st.hst_rdata[`IER_RDA_BIT] = cur_ff.ier_rda;
                    nxt_st.hst_rdata[`IER_RLS_BIT] = cur_ff.ier_rls;
                end
                `HST_LSTAT: begin
                    nxt_st.hst_rdata[`LST_DR_BIT] = !q_if.empty;
                    nxt_st.hst_rdata[`LST_ERR_HI:`LST_ERR_LO] =
                        cur_ff.err;                             // see RULE7
                end
                default: begin
                end
            endcase
        end

        // Local interrupt pending bits: set wins over every clear
        if (pend_rd) begin
            nxt_st.pend[0] = 1'b0;                              // see RULE11
        end
        if (lcl_wr && (lcl_addr == `LCL_IRQ_PEND)) begin
            nxt_st.pend[0] = nxt_st.pend[0]
                             & ~lcl_wdata[`PEND_EMPTY_BIT];
            nxt_st.pend[1] = nxt_st.pend[1]
                             & ~lcl_wdata[`PEND_DROP_BIT];
        end
        if (push_ok) begin
            nxt_st.pend[0] = 1'b0;                              // see RULE11
        end
        if (becomes_empty && cur_ff.qc_en) begin
            nxt_st.pend[0] = 1'b1;                              // see RULE11
        end
        if (push_req && q_if.full) begin
            nxt_st.pend[1] = 1'b1;                              // see RULE12
        end

        // Local register writes and reads
        if (lcl_wr && (lcl_addr == `LCL_IRQ_MASK)) begin
            nxt_st.mask[0] = lcl_wdata[`PEND_EMPTY_BIT];
            nxt_st.mask[1] = lcl_wdata[`PEND_DROP_BIT];
        end
        if (lcl_rd) begin
            unique case (lcl_addr)
                `LCL_IRQ_PEND: begin
                    nxt_st.lcl_rdata[`PEND_EMPTY_BIT] = cur_ff.pend[0];
                    nxt_st.lcl_rdata[`PEND_DROP_BIT]  = cur_ff.pend[1];
                end
                `LCL_IRQ_MASK: begin
                    nxt_st.lcl_rdata[`PEND_EMPTY_BIT] = cur_ff.mask[0];
                    nxt_st.lcl_rdata[`PEND_DROP_BIT]  = cur_ff.mask[1];
                end
                `LCL_COUNT: begin
                    nxt_st.lcl_rdata = {3'h0, q_if.count};
                end
                default: begin
                end
            endcase
        end

        // Interrupt outputs
        nxt_st.irq_host = (cur_ff.ier_rda && q_if.count >= thr) // see RULE10
                          || (cur_ff.ier_rls && (|nxt_st.err)); // see RULE7
        nxt_st.irq_lcl  = |(nxt_st.pend & nxt_st.mask);
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            cur_ff      <= '0;
            cur_ff.mask <= `RST_MASK;
            cur_ff.trig <= `RST_TRIG;
        end else begin
            cur_ff <= nxt_st;
        end
    end

    assign lcl_rdata = cur_ff.lcl_rdata;
    assign hst_rdata = cur_ff.hst_rdata;
    assign irq_host  = cur_ff.irq_host;
    assign irq_lcl   = cur_ff.irq_lcl;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!rst_n);

    AST_DEPTH_LIMIT: // see RULE1
    assert property (q_if.count <= qcnt_t'(`RXQ_DEPTH))
        else $error("queue count above depth");

    AST_SHADOW_CLEARED: // see RULE3
    assert property (push_ok |=> cur_ff.shadow == 3'h0)
        else $error("shadow bits not cleared after store");

    AST_STORED_TOGETHER: // see RULE5
    assert property (push_ok && q_if.empty |=>
        q_if.head == {$past(cur_ff.shadow), $past(lcl_wdata)})
        else $error("head entry differs from written byte and flags");

    AST_FULL_IGNORED: // see RULE12
    assert property (push_req && q_if.full && !pop_req |=>
        q_if.count == qcnt_t'(`RXQ_DEPTH) && cur_ff.pend[1])
        else $error("write while full changed the queue");

    AST_EMPTY_POP: // see RULE12
    assert property (pop_req && q_if.empty && !push_req |=>
        q_if.count == qcnt_t'(0) && hst_rdata == 8'h00)
        else $error("read while empty moved the queue");

    AST_ERR_STICKY: // see RULE9
    assert property (!lstat_rd |=> ($past(cur_ff.err) & ~cur_ff.err) == 3'h0)
        else $error("error bit dropped without status read");

    AST_ERR_READ_CLEAR: // see RULE8
    assert property (lstat_rd && !cur_ff.arrive |=> cur_ff.err == 3'h0)
        else $error("status read did not clear error bits");

    AST_HEAD_FLAGS: // see RULE6
    assert property (cur_ff.arrive && !q_if.empty |=>
        (cur_ff.err & $past(q_if.head.flags)) == $past(q_if.head.flags))
        else $error("head flags not shown to host");

    AST_LSTAT_READBACK: // see RULE7
    assert property (lstat_rd |=>
        hst_rdata[`LST_ERR_HI:`LST_ERR_LO] == $past(cur_ff.err)
        && hst_rdata[`LST_DR_BIT] == !$past(q_if.empty))
        else $error("line status read shows wrong bits");

    AST_TRIGGER_IRQ: // see RULE10
    assert property (cur_ff.ier_rda && q_if.count >= thr |=> irq_host)
        else $error("threshold reached without host interrupt");

    AST_EMPTY_PEND: // see RULE11
    assert property (becomes_empty && cur_ff.qc_en |=>
        cur_ff.pend[0] ##1 (cur_ff.pend[0] || $past(pend_rd)
        || $past(push_ok) || $past(lcl_wr)))
        else $error("drain to empty did not set local pending bit");

    // ------------------------------------------------------------
    // Queue and interrupt checks
    // ------------------------------------------------------------
    AST_SHADOW_HOLD: // see RULE2
    assert property (!shadow_wr && !push_ok |=> $stable(cur_ff.shadow))
        else $error("shadow bits changed without write or store");

    AST_POP_DATA: // see RULE5
    assert property (pop_ok |=> hst_rdata == $past(q_if.head.chr))
        else $error("host data differs from head character");

    AST_POP_STEP: // see RULE12
    assert property (pop_ok && !push_ok |=>
        q_if.count == $past(q_if.count) - qcnt_t'(1))
        else $error("host read did not take one entry");

    AST_PUSH_STEP: // see RULE12
    assert property (push_ok && !pop_ok |=>
        q_if.count == $past(q_if.count) + qcnt_t'(1))
        else $error("local write did not add one entry");

    AST_HEAD_HOLD: // see RULE6
    assert property (!pop_ok && !q_if.empty |=> $stable(q_if.head))
        else $error("head entry changed without host read");

    AST_ERR_AT_HEAD: // see RULE6
    assert property (!cur_ff.arrive |=>
        (cur_ff.err & ~$past(cur_ff.err)) == 3'h0)
        else $error("error bit set without a new head entry");

    AST_RLS_IRQ: // see RULE7
    assert property (cur_ff.ier_rls && (|cur_ff.err) && !lstat_rd |=>
        irq_host)
        else $error("error bits set without host interrupt");

    AST_HOST_IRQ_OFF: // see RULE10
    assert property (!cur_ff.ier_rda && !cur_ff.ier_rls |=> !irq_host)
        else $error("host interrupt without an enable");

    AST_PUSH_UNPEND: // see RULE11
    assert property (push_ok |=> !cur_ff.pend[0])
        else $error("local write left empty pending bit set");

    AST_PEND_RD_CLEAR: // see RULE11
    assert property (pend_rd && !becomes_empty |=> !cur_ff.pend[0])
        else $error("pending read left empty bit set");

    AST_EMPTY_QMODE: // see RULE11
    assert property (!cur_ff.qc_en && !cur_ff.pend[0] |=> !cur_ff.pend[0])
        else $error("empty pending bit set outside queue mode");

    AST_DROP_HOLD: // see RULE12
    assert property (cur_ff.pend[1] && !lcl_wr |=> cur_ff.pend[1])
        else $error("drop pending bit lost without a write");

endmodule

// [logic/queue_store.sv]
// Sixteen-entry storage with read and write pointers
`timescale 1ns/10ps
`include "rxq_params.svh"
module queue_store (
    input  wire logic core_clk,
    input  wire logic rst_n,
    rxq_if.store      q
);
    import rxq_pkg::*;

    typedef struct packed {
        rxq_entry_t [`RXQ_DEPTH-1:0] mem;
        qptr_t                       wr_ptr;
        qptr_t                       rd_ptr;
        qcnt_t                       count;
    } store_state_t;

    store_state_t              cur_ff;
    store_state_t              nxt_st;
    logic                      do_push;
    logic                      do_pop;
    logic [`RXQ_DEPTH-1:0]     we;

    assign do_push = q.push && !q.full;   // see RULE12
    assign do_pop  = q.pop && !q.empty;   // see RULE12

    // ------------------------------------------------------------
    // Per-entry write decode
    // ------------------------------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < `RXQ_DEPTH; gi++) begin : g_we
            assign we[gi] = do_push && (cur_ff.wr_ptr == qptr_t'(gi));
        end
    endgenerate

    always_comb begin
        nxt_st = cur_ff;
        for (int i = 0; i < `RXQ_DEPTH; i++) begin
            if (we[i]) begin
                nxt_st.mem[i] = q.push_entry;   // see RULE5
            end
        end
        if (do_push) begin
            nxt_st.wr_ptr = cur_ff.wr_ptr + qptr_t'(1);
        end
        if (do_pop) begin
            nxt_st.rd_ptr = cur_ff.rd_ptr + qptr_t'(1);
        end
        if (do_push && !do_pop) begin
            nxt_st.count = cur_ff.count + qcnt_t'(1);
        end else if (do_pop && !do_push) begin
            nxt_st.count = cur_ff.count - qcnt_t'(1);
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            cur_ff <= '0;
        end else begin
            cur_ff <= nxt_st;
        end
    end

    assign q.head  = cur_ff.mem[cur_ff.rd_ptr];   // see RULE6
    assign q.count = cur_ff.count;
    assign q.full  = (cur_ff.count == qcnt_t'(`RXQ_DEPTH));   // see RULE1
    assign q.empty = (cur_ff.count == qcnt_t'(0));
endmodule

// [logic/rxq_if.sv]
// Link between queue control and queue storage
`timescale 1ns/10ps
interface rxq_if;
    rxq_pkg::rxq_entry_t push_entry;
    logic                push;
    logic                pop;
    rxq_pkg::rxq_entry_t head;
    rxq_pkg::qcnt_t      count;
    logic                full;
    logic                empty;

    modport ctl (output push, push_entry, pop,
                 input  head, count, full, empty);
    modport store (input  push, push_entry, pop,
                   output head, count, full, empty);
endinterface

// [logic/rxq_params.svh]
// Constants of the host receive queue with per-character error bits
// How it works
// RULE1 - Sixteen entries: byte plus three error bits
// RULE2 - Entry flags come from local shadow bits
// RULE3 - Shadow bits clear after copy into queue
// RULE4 - Local side writes status before character
// RULE5 - Byte and shadow flags share one slot
// RULE6 - Flags visible only once entry heads queue
// RULE7 - Head flags readable, raise enabled host interrupt
// RULE8 - Host flags set from head, read clears
// RULE9 - Flags accumulate over reads without status read
// RULE10 - Host interrupt at 1/4/8/14 byte threshold
// RULE11 - Local interrupt when queue drains empty; code sets the empty pending bit only while qc_en is set
// RULE12 - Pointers track fill; full writes, empty reads ignored
`ifndef RXQ_PARAMS_SVH
`define RXQ_PARAMS_SVH

// ----------------------------------------------------------------
// Queue geometry
// ----------------------------------------------------------------
`define RXQ_DEPTH       16
`define RXQ_AW          4
`define RXQ_CW          5
`define RXQ_ADDR_W      3

// ----------------------------------------------------------------
// Local processor register offsets
// ----------------------------------------------------------------
`define LCL_RXDATA      3'h0
`define LCL_IRQ_PEND    3'h2
`define LCL_IRQ_MASK    3'h3
`define LCL_COUNT       3'h4
`define LCL_SHADOW      3'h5

// ----------------------------------------------------------------
// Host register offsets
// ----------------------------------------------------------------
`define HST_RXDATA      3'h0
`define HST_IER         3'h1
`define HST_QCTRL       3'h2
`define HST_LSTAT       3'h5

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define LST_DR_BIT      0
`define LST_ERR_LO      2
`define LST_ERR_HI      4
`define IER_RDA_BIT     0
`define IER_RLS_BIT     2
`define QC_EN_BIT       0
`define QC_TRIG_LO      6
`define QC_TRIG_HI      7
`define PEND_EMPTY_BIT  5
`define PEND_DROP_BIT   6

// ----------------------------------------------------------------
// Thresholds and reset values
// ----------------------------------------------------------------
`define TRIG_1          5'h01
`define TRIG_4          5'h04
`define TRIG_8          5'h08
`define TRIG_14         5'h0e
`define RST_MASK        2'h0
`define RST_TRIG        2'h0

`endif

// [logic/rxq_pkg.sv]
// Types shared by the receive queue modules
package rxq_pkg;

    typedef logic [2:0] addr_t;
    typedef logic [7:0] byte_t;
    typedef logic [3:0] qptr_t;
    typedef logic [4:0] qcnt_t;

    typedef struct packed {
        logic brk;
        logic fe;
        logic pe;
    } err3_t;

    typedef struct packed {
        err3_t flags;
        byte_t chr;
    } rxq_entry_t;

endpackage
